// ==== rtl/fsc_fifo.sv ====
// Purpose: Sample FIFO with valid/ready on both sides
// Assumes: Depth is a power of two
// Notes:   Pointers carry one extra wrap bit
`timescale 1ns/10ps
module fsc_fifo #(
   parameter int W = 24,
   parameter int D = 8
) (
   input  wire logic         sys_clk,
   input  wire logic         rst,
   input  wire logic         in_valid,
   input  wire logic [W-1:0] in_data,
   output logic              in_ready,
   output logic              out_valid,
   output logic      [W-1:0] out_data,
   input  wire logic         out_ready
);
   localparam int AW = $clog2(D);
   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW:0]         wp;
      logic [AW:0]         rp;
   } fsc_fifo_st_t;
   fsc_fifo_st_t r, next_r;

   assign in_ready  = (r.wp - r.rp) != (AW+1)'(D);
   assign out_valid = r.wp != r.rp;
   assign out_data  = r.mem[r.rp[AW-1:0]];

   always_comb begin
      next_r = r;
      if (in_valid && in_ready) begin
         next_r.mem[r.wp[AW-1:0]] = in_data;
         next_r.wp = r.wp + 1'b1;
      end
      if (out_valid && out_ready) next_r.rp = r.rp + 1'b1;
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) r <= '0;
      else r <= next_r;
   end
endmodule // fsc_fifo

// ==== rtl/fsc_lpf.sv ====
// Purpose: Recursive first-order smoothing stage
// Assumes: One update per enable, coefficient 2^-k
// Notes:   Load replaces the state outright
`timescale 1ns/10ps
module fsc_lpf
   import fsc_pkg::*;
(
   input  wire logic                    sys_clk,
   input  wire logic                    rst,
   input  wire logic                    en,
   input  wire logic                    load,
   input  wire logic signed [FSC_W-1:0] x,
   input  wire logic              [3:0] k,
   output logic signed      [FSC_W-1:0] y
);
   typedef struct packed {
      logic signed [FSC_W-1:0] y;
   } fsc_lpf_st_t;
   fsc_lpf_st_t r, next_r;

   assign y = r.y;

   always_comb begin
      next_r = r;
      if (en && load) next_r.y = x;
      else if (en) next_r.y = fsc_lp(r.y, x, k);
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) r <= '0;
      else r <= next_r;
   end
endmodule // fsc_lpf

// ==== rtl/fsc_pkg.sv ====
// Purpose: Shared constants, types and helpers for flow conditioning
// Assumes: 50 MHz clock, one flow sample every 8 ms
// Notes:   Flow values are signed two's complement
package fsc_pkg;
   localparam int FSC_W         = 24;
   localparam int FSC_CLK_NS    = 20;
   localparam int FSC_MS_NS     = 1000000;
   localparam int FSC_HOLD_MS   = 3000;
   localparam int FSC_ALT_MS    = 7000;
   localparam int FSC_TAU_MS    = 1000;
   localparam int FSC_SAMPLE_SH = 3;
   localparam int FSC_FIFO_D    = 8;
   localparam logic [FSC_W-1:0] FSC_FULL_SCALE = 24'h40_0000;
   localparam logic [FSC_W-1:0] FSC_CUTOFF_DEF = FSC_W'(FSC_FULL_SCALE * 5 / 1000);
   localparam logic [FSC_W-1:0] FSC_STEP_DEF   = FSC_W'(FSC_FULL_SCALE * 99 / 100);
   localparam int FSC_K_MENU  = 0;
   localparam int FSC_K_RESET = 1;
   localparam int FSC_K_DISP  = 2;
   localparam int FSC_K_INFO  = 3;

   typedef enum logic [1:0] {
      FSC_VC_FLOW_TOTAL = 2'h0,
      FSC_VC_DENS_TEMP  = 2'h1
   } fsc_view_t;
   typedef enum logic [1:0] {
      FSC_U_MASS = 2'h0, FSC_U_MASS_RATE = 2'h1, FSC_U_VOL = 2'h2, FSC_U_VOL_RATE = 2'h3
   } fsc_unit_t;
   typedef enum logic [1:0] {
      FSC_S_IDLE = 2'b00, FSC_S_PRIM = 2'b01, FSC_S_DISP = 2'b10, FSC_S_OUT = 2'b11
   } fsc_phase_t;

   typedef struct packed {
      logic                    valid;
      logic signed [FSC_W-1:0] flow;
      logic signed [FSC_W-1:0] disp;
      logic                    hold;
   } fsc_flow_t;

   typedef struct packed {
      logic              [15:0] flow_tau_ms;
      logic              [15:0] disp_tau_ms;
      logic         [FSC_W-1:0] cutoff;
      logic         [FSC_W-1:0] step;
      logic                     batch_key_en;
      fsc_view_t                view1;
      fsc_view_t                view2;
      logic                     alt_mode;
   } fsc_cfg_t;

   function automatic logic [FSC_W:0] fsc_abs(input logic signed [FSC_W:0] v);
      fsc_abs = v[FSC_W] ? -v : v;
   endfunction

   function automatic logic signed [FSC_W-1:0] fsc_lp(input logic signed [FSC_W-1:0] y,
                                                      input logic signed [FSC_W-1:0] x,
                                                      input logic [3:0] k);
      logic signed [FSC_W:0] d;
      logic signed [FSC_W:0] s;
      d = {x[FSC_W-1], x} - {y[FSC_W-1], y};
      d = d >>> k;
      s = {y[FSC_W-1], y} + d;
      fsc_lp = s[FSC_W-1:0];
   endfunction

   function automatic logic [3:0] fsc_tau_shift(input logic [15:0] tau_ms);
      logic [15:0] q;
      q = tau_ms >> FSC_SAMPLE_SH;
      fsc_tau_shift = 4'h0;
      for (int i = 0; i < 15; i++) begin
         if (q > (16'h0001 << i)) fsc_tau_shift = 4'(i + 1);
      end
   endfunction
endpackage

// ==== rtl/fsc_top.sv ====
// Function
// - Mass mode accepts only mass units
// - Subtract stored zero offset from sample
// - Filters are first-order, set by tau
// - Primary filter feeds all outputs, 1 s
// - Readout filter smooths display only, 1 s
// - Below cutoff: zero flow, hold totals
// - Cutoff default half percent full scale
// - Small jump keeps primary filter running
// - Large jump reloads primary filter state
// - Jump threshold default ninety-nine percent
// - Menu key held 3 s opens menu
// - Reset key clears batch when enabled
// - Batch clear key disabled by default
// - Info key opens diagnostics
// - Two views, factory flow/total, density/temp
// - Fixed mode: display key toggles view
// - Alternate mode switches every 7 s
// - Alternate mode ignores display key
//
// Purpose: Flow conditioning and measuring-mode key handling
// Assumes: Keys are debounced, active high, synchronous
// Notes:   Config ports apply only while cfg_custom is high
`timescale 1ns/10ps
module fsc_top
   import fsc_pkg::*;
#(
   parameter int TICK_CYCLES = FSC_MS_NS / FSC_CLK_NS,
   parameter int HOLD_MS     = FSC_HOLD_MS,
   parameter int ALT_MS      = FSC_ALT_MS
) (
   input  wire logic                    sys_clk,
   input  wire logic                    rst,
   input  wire logic                    sample_valid,
   input  wire logic        [FSC_W-1:0] sample_shift,
   output logic                         sample_ready,
   input  wire logic        [FSC_W-1:0] zero_offset,
   input  wire logic                    mass_mode,
   input  wire fsc_pkg::fsc_unit_t      unit_req,
   output logic                         unit_ok,
   input  wire logic                    cfg_custom,
   input  wire fsc_pkg::fsc_cfg_t       cfg,
   input  wire logic                    meas_mode,
   input  wire logic              [3:0] keys,
   output fsc_pkg::fsc_flow_t           flow_o,
   input  wire logic                    flow_ready,
   output logic                         menu_open,
   output logic                         diag_open,
   output logic                         batch_clear,
   output logic                         view_sel,
   output fsc_pkg::fsc_view_t           view_content
);
   typedef struct packed {
      fsc_phase_t              phase;
      logic signed [FSC_W-1:0] corr;
      fsc_flow_t               out;
      logic              [3:0] key_prev;
      logic             [15:0] tick_cnt;
      logic             [12:0] hold_ms;
      logic                    hold_done;
      logic             [12:0] alt_ms;
      logic                    view;
      fsc_view_t               view_c;
      logic                    menu;
      logic                    diag;
      logic                    bclr;
      logic                    unit_ok;
   } fsc_st_t;
   fsc_st_t r, next_r;

   ////////////////////////////////////////////////////////////////////////////
   // Effective configuration
   fsc_cfg_t                cfg_e;
   logic              [3:0] k_flow;
   logic              [3:0] k_disp;
   logic                    fifo_valid;
   logic        [FSC_W-1:0] fifo_data;
   logic                    pop;
   logic                    prim_en;
   logic                    disp_en;
   logic                    jump;
   logic signed [FSC_W-1:0] y_prim;
   logic signed [FSC_W-1:0] y_disp;
   logic              [3:0] press;
   logic                    ms_tick;

   always_comb begin
      cfg_e              = cfg;
      if (!cfg_custom) begin
         cfg_e.flow_tau_ms  = 16'(FSC_TAU_MS);
         cfg_e.disp_tau_ms  = 16'(FSC_TAU_MS);
         cfg_e.cutoff       = FSC_CUTOFF_DEF;
         cfg_e.step         = FSC_STEP_DEF;
         cfg_e.batch_key_en = 1'b0;
         cfg_e.view1        = FSC_VC_FLOW_TOTAL;
         cfg_e.view2        = FSC_VC_DENS_TEMP;
         cfg_e.alt_mode     = 1'b0;
      end
   end

   assign k_flow  = fsc_tau_shift(cfg_e.flow_tau_ms);
   assign k_disp  = fsc_tau_shift(cfg_e.disp_tau_ms);
   assign press   = keys & ~r.key_prev;
   assign ms_tick = r.tick_cnt == 16'(TICK_CYCLES - 1);

   ////////////////////////////////////////////////////////////////////////////
   // Sample buffer and filters
   fsc_fifo #(
      .W (FSC_W),
      .D (FSC_FIFO_D)
   ) u_fifo (
      .sys_clk   (sys_clk),
      .rst       (rst),
      .in_valid  (sample_valid),
      .in_data   (sample_shift),
      .in_ready  (sample_ready),
      .out_valid (fifo_valid),
      .out_data  (fifo_data),
      .out_ready (pop)
   );

   fsc_lpf u_prim (
      .sys_clk (sys_clk),
      .rst     (rst),
      .en      (prim_en),
      .load    (jump),
      .x       (r.corr),
      .k       (k_flow),
      .y       (y_prim)
   );

   fsc_lpf u_disp (
      .sys_clk (sys_clk),
      .rst     (rst),
      .en      (disp_en),
      .load    (1'b0),
      .x       (y_prim),
      .k       (k_disp),
      .y       (y_disp)
   );

   assign flow_o       = r.out;
   assign menu_open    = r.menu;
   assign diag_open    = r.diag;
   assign batch_clear  = r.bclr;
   assign view_sel     = r.view;
   assign view_content = r.view_c;
   assign unit_ok      = r.unit_ok;

   ////////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      next_r      = r;
      next_r.menu = 1'b0;
      next_r.diag = 1'b0;
      next_r.bclr = 1'b0;
      pop         = 1'b0;
      prim_en     = 1'b0;
      disp_en     = 1'b0;
      jump        = 1'b0;
      if (r.out.valid && flow_ready) next_r.out.valid = 1'b0;
      case (r.phase)
         FSC_S_IDLE: begin
            if (fifo_valid && !r.out.valid) begin
               pop          = 1'b1;
               next_r.corr  = fifo_data - zero_offset;
               next_r.phase = FSC_S_PRIM;
            end
         end
         FSC_S_PRIM: begin
            prim_en      = 1'b1;
            jump         = fsc_abs({r.corr[FSC_W-1], r.corr} - {y_prim[FSC_W-1], y_prim})
                           > {1'b0, cfg_e.step};
            next_r.phase = FSC_S_DISP;
         end
         FSC_S_DISP: begin
            disp_en      = 1'b1;
            next_r.phase = FSC_S_OUT;
         end
         FSC_S_OUT: begin
            next_r.out.hold  = fsc_abs({y_prim[FSC_W-1], y_prim}) < {1'b0, cfg_e.cutoff};
            next_r.out.flow  = next_r.out.hold ? '0 : y_prim;
            next_r.out.disp  = next_r.out.hold ? '0 : y_disp;
            next_r.out.valid = 1'b1;
            next_r.phase     = FSC_S_IDLE;
         end
         default: next_r.phase = FSC_S_IDLE;
      endcase

      next_r.key_prev = keys;
      next_r.tick_cnt = ms_tick ? 16'h0000 : r.tick_cnt + 16'h0001;
      if (meas_mode && keys[FSC_K_MENU]) begin
         if (ms_tick && !r.hold_done) begin
            if (r.hold_ms == 13'(HOLD_MS - 1)) begin
               next_r.menu      = 1'b1;
               next_r.hold_done = 1'b1;
            end else begin
               next_r.hold_ms = r.hold_ms + 13'h0001;
            end
         end
      end else begin
         next_r.hold_ms   = 13'h0000;
         next_r.hold_done = 1'b0;
      end
      if (meas_mode) begin
         if (press[FSC_K_RESET] && cfg_e.batch_key_en) next_r.bclr = 1'b1;
         if (press[FSC_K_INFO]) next_r.diag = 1'b1;
         if (cfg_e.alt_mode) begin
            if (ms_tick) begin
               if (r.alt_ms == 13'(ALT_MS - 1)) begin
                  next_r.alt_ms = 13'h0000;
                  next_r.view   = ~r.view;
               end else begin
                  next_r.alt_ms = r.alt_ms + 13'h0001;
               end
            end
         end else begin
            next_r.alt_ms = 13'h0000;
            if (press[FSC_K_DISP]) next_r.view = ~r.view;
         end
      end
      next_r.view_c  = next_r.view ? cfg_e.view2 : cfg_e.view1;
      next_r.unit_ok = mass_mode ? (unit_req == FSC_U_MASS || unit_req == FSC_U_MASS_RATE)
                                 : (unit_req == FSC_U_VOL || unit_req == FSC_U_VOL_RATE);
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) r <= '0;
      else r <= next_r;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   sequence s_pipe;
      r.phase == FSC_S_PRIM ##1 r.phase == FSC_S_DISP ##1 r.phase == FSC_S_OUT;
   endsequence

   sequence s_cut;
      r.phase == FSC_S_OUT && fsc_abs({y_prim[FSC_W-1], y_prim}) < {1'b0, cfg_e.cutoff};
   endsequence

   a_pipe_order: assert property (pop |=> s_pipe ##1 flow_o.valid)
      else $error("Sample pipeline order broken");
   a_offset_sub: assert property (pop |=> r.corr == $past(fifo_data) - $past(zero_offset))
      else $error("Zero offset not subtracted");
   a_jump_load: assert property (prim_en && jump |=> y_prim == $past(r.corr))
      else $error("Jump did not reload filter");
   a_filt_run: assert property (prim_en && !jump
         |=> y_prim == fsc_lp($past(y_prim), $past(r.corr), $past(k_flow)))
      else $error("Primary filter step wrong");
   a_disp_stage: assert property (disp_en
         |=> y_disp == fsc_lp($past(y_disp), $past(y_prim), $past(k_disp)))
      else $error("Readout filter step wrong");
   a_cutoff_zero: assert property (s_cut
         |=> flow_o.valid && flow_o.hold && flow_o.flow == '0 && flow_o.disp == '0)
      else $error("Cutoff did not force zero");
   a_batch_key: assert property (meas_mode && press[FSC_K_RESET]
         |=> batch_clear == $past(cfg_e.batch_key_en))
      else $error("Batch clear key wrong");
   a_diag_key: assert property (meas_mode && press[FSC_K_INFO] |=> diag_open)
      else $error("Info key ignored");
   a_menu_hold: assert property (menu_open
         |-> $past(r.hold_ms) == 13'(HOLD_MS - 1) && $past(keys[FSC_K_MENU]))
      else $error("Menu opened without full hold");
   a_view_fixed: assert property (meas_mode && !cfg_e.alt_mode && press[FSC_K_DISP]
         |=> view_sel != $past(view_sel))
      else $error("Display key did not toggle");
   a_alt_ignore: assert property (meas_mode && cfg_e.alt_mode && !ms_tick
         |=> view_sel == $past(view_sel))
      else $error("View changed between alternation steps");
   a_unit_class: assert property (mass_mode && unit_req == FSC_U_VOL |=> !unit_ok)
      else $error("Volume unit accepted in mass mode");
endmodule // fsc_top

// ==== verification/fsc_front.sv ====
// Purpose: Sensor front end model offering raw flow samples
// Assumes: Samples queued by the bench, one offered at a time
// Notes:   Idle data lines show the inverse of the last word
`timescale 1ns/10ps
module fsc_front
   import fsc_pkg::*;
(
   input  wire logic             sys_clk,
   input  wire logic             sample_ready,
   output logic                  sample_valid,
   output logic      [FSC_W-1:0] sample_shift
);
   logic [FSC_W-1:0] pend[$];
   logic [FSC_W-1:0] last;
   int               gap;
   int               idle;
   initial begin
      sample_valid = 1'b0;
      sample_shift = '0;
      last = '0;
      gap = 0;
      idle = 0;
   end
   task automatic push(input logic [FSC_W-1:0] v);
      pend.push_back(v);
   endtask
   // Offer and hold one word until taken, optional idle gap after
   always @(negedge sys_clk) begin
      if (pend.size() > 0 && idle == 0) begin
         sample_valid <= 1'b1;
         sample_shift <= pend[0];
         last <= pend[0];
      end else begin
         sample_valid <= 1'b0;
         sample_shift <= ~last;
      end
   end
   // Gap counter runs down only while nothing is offered
   always @(posedge sys_clk) begin
      if (sample_valid && sample_ready) begin
         void'(pend.pop_front());
         idle <= gap;
      end else if (!sample_valid && idle > 0) begin
         idle <= idle - 1;
      end
   end
endmodule // fsc_front

// ==== verification/fsc_top_bench.sv ====
// Purpose: Self-checking bench for flow conditioning and keys
// Assumes: 4-cycle ms tick, 3 ms menu hold, 7 ms alternation
// Notes:   Inputs change at the falling edge
`timescale 1ns/10ps
module fsc_top_bench;
   import fsc_pkg::*;
   logic             sys_clk, rst, sample_valid, sample_ready, mass_mode, unit_ok;
   logic [FSC_W-1:0] sample_shift, zero_offset;
   fsc_unit_t        unit_req;
   logic             cfg_custom, meas_mode, flow_ready;
   fsc_cfg_t         cfg;
   logic       [3:0] keys;
   fsc_flow_t        flow_o, f;
   logic             menu_open, diag_open, batch_clear, view_sel;
   fsc_view_t        view_content;
   int               failures, checks_done, cycles;
   int               cnt[4];
   localparam logic [FSC_W-1:0] BIG = 24'h3F_8000;
   fsc_front front (.sys_clk(sys_clk), .sample_ready(sample_ready),
      .sample_valid(sample_valid), .sample_shift(sample_shift));
   fsc_top #(.TICK_CYCLES(4), .HOLD_MS(3), .ALT_MS(7)) uut (.sys_clk(sys_clk), .rst(rst),
      .sample_valid(sample_valid), .sample_shift(sample_shift), .sample_ready(sample_ready),
      .zero_offset(zero_offset), .mass_mode(mass_mode), .unit_req(unit_req),
      .unit_ok(unit_ok), .cfg_custom(cfg_custom), .cfg(cfg), .meas_mode(meas_mode),
      .keys(keys), .flow_o(flow_o), .flow_ready(flow_ready), .menu_open(menu_open),
      .diag_open(diag_open), .batch_clear(batch_clear), .view_sel(view_sel),
      .view_content(view_content));
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         failures++;
         finish_test();
      end
   end
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic take();
      int n;
      n = 0;
      while (flow_o.valid !== 1'b1 && n < 300) begin
         @(negedge sys_clk);
         n++;
      end
      f = flow_o;
      chk("flow valid", 1, f.valid);
      flow_ready = 1'b1;
      @(negedge sys_clk);
      flow_ready = 1'b0;
   endtask
   task automatic press(input int idx, input int hold, input int span);
      logic vs;
      vs = view_sel;
      cnt = '{0, 0, 0, 0};
      if (idx >= 0) keys[idx] = 1'b1;
      for (int i = 0; i < span; i++) begin
         @(negedge sys_clk);
         if (idx >= 0 && i == hold - 1) keys[idx] = 1'b0;
         cnt[0] += int'(menu_open === 1'b1);
         cnt[1] += int'(diag_open === 1'b1);
         cnt[2] += int'(batch_clear === 1'b1);
         cnt[3] += int'(view_sel !== vs);
         vs = view_sel;
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      chk("valid", 0, flow_o.valid);
      chk("ready", 1, sample_ready);
      chk("view_sel", 0, view_sel);
      chk("view", FSC_VC_FLOW_TOTAL, view_content);
      $display("test reset done");
   endtask
   task automatic t_units();
      for (int m = 0; m < 2; m++) begin
         for (int u = 0; u < 4; u++) begin
            mass_mode = m[0];
            unit_req = fsc_unit_t'(u);
            repeat (2) @(negedge sys_clk);
            chk("unit_ok", (m == 1) == (u < 2), unit_ok);
         end
      end
      $display("test units done");
   endtask
   task automatic t_jump();
      zero_offset = 24'h00_1234;
      front.gap = 3;
      front.push(BIG + 24'h00_1234);
      front.push(BIG + 24'h00_0234);
      take();
      chk("flow", BIG, f.flow);
      chk("disp", 24'h00_7F00, f.disp);
      chk("hold", 0, f.hold);
      take();
      chk("flow", 24'h3F_7FE0, f.flow);
      chk("disp", 24'h00_FD01, f.disp);
      zero_offset = '0;
      front.gap = 0;
      $display("test jump done");
   endtask
   task automatic t_cutoff();
      logic [FSC_W-1:0] in[5] = '{24'h00_0000, 24'hC0_8000, 24'd20970, 24'hC0_8000, 24'd20971};
      logic [FSC_W-1:0] ex[5] = '{24'h00_0000, 24'hC0_8000, 24'h00_0000, 24'hC0_8000, 24'd20971};
      logic             hd[5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
      for (int i = 0; i < 5; i++) begin
         front.push(in[i]);
         take();
         chk("hold", hd[i], f.hold);
         chk("flow", ex[i], $unsigned(f.flow));
         if (hd[i]) chk("disp", 0, f.disp);
      end
      $display("test cutoff done");
   endtask
   task automatic t_fifo();
      int n;
      n = 0;
      for (int i = 0; i < 10; i++) front.push(i[0] ? BIG + 24'(i) : 24'hC0_8000 - 24'(i));
      while (sample_ready !== 1'b0 && n < 100) begin
         @(negedge sys_clk);
         n++;
      end
      chk("ready full", 0, sample_ready);
      repeat (6) @(negedge sys_clk);
      chk("valid stands", 1, flow_o.valid);
      for (int i = 0; i < 10; i++) begin
         take();
         chk("order", i[0] ? BIG + 24'(i) : 24'hC0_8000 - 24'(i), $unsigned(f.flow));
      end
      repeat (8) @(negedge sys_clk);
      chk("empty valid", 0, flow_o.valid);
      chk("ready", 1, sample_ready);
      $display("test fifo done");
   endtask
   task automatic t_keys();
      meas_mode = 1'b1;
      press(3, 1, 4);
      chk("diag", 1, cnt[1]);
      press(1, 1, 4);
      chk("batch", 0, cnt[2]);
      press(2, 1, 4);
      chk("view", FSC_VC_DENS_TEMP, view_content);
      press(2, 1, 4);
      chk("toggles", 2, cnt[3] + int'(view_sel === 1'b0));
      press(0, 6, 10);
      chk("menu short", 0, cnt[0]);
      press(0, 24, 28);
      chk("menu", 1, cnt[0]);
      cfg = '{16'd1000, 16'd1000, 24'd20971, 24'h3F_5C28, 1'b1,
              FSC_VC_DENS_TEMP, FSC_VC_FLOW_TOTAL, 1'b0};
      cfg_custom = 1'b1;
      press(1, 1, 4);
      chk("batch en", 1, cnt[2]);
      chk("view1", FSC_VC_DENS_TEMP, view_content);
      meas_mode = 1'b0;
      press(3, 1, 4);
      chk("diag off", 0, cnt[1]);
      meas_mode = 1'b1;
      cfg.alt_mode = 1'b1;
      press(2, 1, 10);
      chk("alt key", 0, cnt[3]);
      press(-1, 0, 60);
      chk("alt flips", 2, cnt[3]);
      $display("test keys done");
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      failures = 0;
      checks_done = 0;
      rst = 1'b1;
      zero_offset = '0;
      mass_mode = 1'b1;
      unit_req = FSC_U_MASS;
      cfg_custom = 1'b0;
      cfg = '0;
      meas_mode = 1'b0;
      keys = 4'h0;
      flow_ready = 1'b0;
      repeat (4) @(negedge sys_clk);
      rst = 1'b0;
      @(negedge sys_clk);
      t_reset();
      t_units();
      t_jump();
      t_cutoff();
      t_fifo();
      t_keys();
      finish_test();
   end
endmodule // fsc_top_bench
